/* logic/lock_cfg_pkg.sv */
package lock_cfg_pkg;
    // ---------------------------------------------------------------
    // Register addresses
    // ---------------------------------------------------------------
    localparam logic [4:0] ADDR_STATUS   = 5'h00;
    localparam logic [4:0] ADDR_ST1      = 5'h01;
    localparam logic [4:0] ADDR_ST2      = 5'h02;
    localparam logic [4:0] ADDR_LOCK_EN  = 5'h03;
    localparam logic [4:0] ADDR_LOCKCFG  = 5'h05;
    localparam logic [4:0] ADDR_OUTCFG   = 5'h0b;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int LOCK_FLAG_BIT  = 2;
    localparam int ST1_INV_BIT    = 7;
    localparam int ST2_INV_BIT    = 7;
    localparam int LOCK_EN_BIT    = 3;
    localparam int LOCK_CNT_LSB   = 4;
    localparam int LOCK_WIN_LSB   = 6;
    localparam int OUTTYPE_BIT    = 2;
    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic       ST1_INV_RST  = 1'h0;
    localparam logic       ST2_INV_RST  = 1'h0;
    localparam logic       LOCK_EN_RST  = 1'h1;
    localparam logic [1:0] LOCK_CNT_RST = 2'h1;
    localparam logic [1:0] LOCK_WIN_RST = 2'h2;
    localparam logic       OUTTYPE_RST  = 1'h0;
    // ---------------------------------------------------------------
    // Lock counts and window times
    // ---------------------------------------------------------------
    localparam logic [11:0] LOCK_COUNT_0 = 12'h020;
    localparam logic [11:0] LOCK_COUNT_1 = 12'h080;
    localparam logic [11:0] LOCK_COUNT_2 = 12'h200;
    localparam logic [11:0] LOCK_COUNT_3 = 12'h800;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int WIN0_NS = 3;
    localparam int WIN1_NS = 10;
    localparam int WIN2_NS = 30;
    localparam int WIN3_NS = 90;
    // All window times round down, never below one cycle
    localparam int WIN0_CYC_RAW = (WIN0_NS * 1000) / CLK_PERIOD_PS;
    localparam int WIN1_CYC_RAW = (WIN1_NS * 1000) / CLK_PERIOD_PS;
    localparam int WIN2_CYC_RAW = (WIN2_NS * 1000) / CLK_PERIOD_PS;
    localparam int WIN3_CYC_RAW = (WIN3_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [7:0] WIN0_CYC = 8'((WIN0_CYC_RAW < 1) ? 1 : WIN0_CYC_RAW);
    localparam logic [7:0] WIN1_CYC = 8'((WIN1_CYC_RAW < 1) ? 1 : WIN1_CYC_RAW);
    localparam logic [7:0] WIN2_CYC = 8'((WIN2_CYC_RAW < 1) ? 1 : WIN2_CYC_RAW);
    localparam logic [7:0] WIN3_CYC = 8'((WIN3_CYC_RAW < 1) ? 1 : WIN3_CYC_RAW);
endpackage

/* logic/lock_detector.sv */
module lock_detector
    import lock_cfg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       refTick,
    input  wire logic       errValid,
    input  wire logic [7:0] errWidth,
    input  wire logic [1:0] lockCountSel,
    input  wire logic [1:0] lockWindowSel,
    output logic            locked
);
    logic [11:0] target;
    logic [7:0]  window;
    logic [11:0] count_q;
    logic        tooWide;

    // ---------------------------------------------------------------
    // Count and window decode
    // ---------------------------------------------------------------
    always_comb begin
        case (lockCountSel)
            2'h0:    target = LOCK_COUNT_0;
            2'h1:    target = LOCK_COUNT_1;
            2'h2:    target = LOCK_COUNT_2;
            default: target = LOCK_COUNT_3;
        endcase
        case (lockWindowSel)
            2'h0:    window = WIN0_CYC;
            2'h1:    window = WIN1_CYC;
            2'h2:    window = WIN2_CYC;
            default: window = WIN3_CYC;
        endcase
    end

    assign tooWide = errValid && (errWidth > window);

    // ---------------------------------------------------------------
    // Consecutive in-window reference cycles
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 12'h000;
            locked  <= 1'b0;
        end else if (tooWide) begin
            count_q <= 12'h000;
            locked  <= 1'b0;
        end else if (refTick) begin
            if (count_q < target) begin
                count_q <= count_q + 12'h001;
            end
            locked <= (count_q + 12'h001 >= target);
        end
    end
endmodule

/* logic/pll_lock_indicator_config.sv */
// Notes on behaviour
// - First status polarity bit inverts first status output
// - Second status polarity bit inverts second status output
// - Lock count selects 32/128/512/2048 cycles
// - Lock indicator enable, resets to one
// - Lock window selects 3/10/30/90 ns
// - Read-only lock flag, locked and enabled
// - Output type: differential pair or two CMOS
module pll_lock_indicator_config
    import lock_cfg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [4:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic [7:0]      regRdata_q,
    input  wire logic       refTickPin,
    input  wire logic       errValidPin,
    input  wire logic [7:0] errWidthPin,
    input  wire logic       statusOneSrc,
    input  wire logic       statusTwoSrc,
    output logic            firstStatusOutput_q,
    output logic            secondStatusOutput_q,
    output logic            auxOutputDiff_q,
    output logic            auxOutputCmos_q
);
    logic       statusOneInvert_q;
    logic       statusTwoInvert_q;
    logic       lockIndicatorEnable_q;
    logic [1:0] lockCountSelect_q;
    logic [1:0] lockWindowSelect_q;
    logic       auxOutputTypeSelect_q;
    logic [1:0] tickSync_q;
    logic [1:0] errSync_q;
    logic [7:0] widthSync0_q;
    logic [7:0] widthSync1_q;
    logic [1:0] st1Sync_q;
    logic [1:0] st2Sync_q;
    logic       tickPrev_q;
    logic       errPrev_q;
    logic       locked;
    logic       lockFlag;
    logic       tickEdge;
    logic       errEdge;

    // ---------------------------------------------------------------
    // Reference tick synchroniser and edge detect
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tickSync_q <= 2'h0;
            tickPrev_q <= 1'b0;
        end else begin
            tickSync_q <= {tickSync_q[0], refTickPin};
            tickPrev_q <= tickSync_q[1];
        end
    end

    assign tickEdge = tickSync_q[1] && !tickPrev_q;

    // ---------------------------------------------------------------
    // Error strobe synchroniser and edge detect
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            errSync_q <= 2'h0;
            errPrev_q <= 1'b0;
        end else begin
            errSync_q <= {errSync_q[0], errValidPin};
            errPrev_q <= errSync_q[1];
        end
    end

    assign errEdge = errSync_q[1] && !errPrev_q;

    // ---------------------------------------------------------------
    // Error width synchronisers, one pair per bit
    // ---------------------------------------------------------------
    for (genvar i = 0; i < 8; i++) begin : g_width_sync
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                widthSync0_q[i] <= 1'b0;
                widthSync1_q[i] <= 1'b0;
            end else begin
                widthSync0_q[i] <= errWidthPin[i];
                widthSync1_q[i] <= widthSync0_q[i];
            end
        end
    end

    // ---------------------------------------------------------------
    // Status source synchronisers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st1Sync_q <= 2'h0;
        end else begin
            st1Sync_q <= {st1Sync_q[0], statusOneSrc};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st2Sync_q <= 2'h0;
        end else begin
            st2Sync_q <= {st2Sync_q[0], statusTwoSrc};
        end
    end

    // ---------------------------------------------------------------
    // Register writes, address zero is read-only
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            statusOneInvert_q <= ST1_INV_RST;
        end else if (regWrite && regAddr == ADDR_ST1) begin
            statusOneInvert_q <= regWdata[ST1_INV_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            statusTwoInvert_q <= ST2_INV_RST;
        end else if (regWrite && regAddr == ADDR_ST2) begin
            statusTwoInvert_q <= regWdata[ST2_INV_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lockIndicatorEnable_q <= LOCK_EN_RST;
        end else if (regWrite && regAddr == ADDR_LOCK_EN) begin
            lockIndicatorEnable_q <= regWdata[LOCK_EN_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lockCountSelect_q <= LOCK_CNT_RST;
        end else if (regWrite && regAddr == ADDR_LOCKCFG) begin
            lockCountSelect_q <= regWdata[LOCK_CNT_LSB +: 2];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lockWindowSelect_q <= LOCK_WIN_RST;
        end else if (regWrite && regAddr == ADDR_LOCKCFG) begin
            lockWindowSelect_q <= regWdata[LOCK_WIN_LSB +: 2];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auxOutputTypeSelect_q <= OUTTYPE_RST;
        end else if (regWrite && regAddr == ADDR_OUTCFG) begin
            auxOutputTypeSelect_q <= regWdata[OUTTYPE_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Lock detection
    // ---------------------------------------------------------------
    lock_detector u_detector (
        .clk           (clk),
        .rst_n         (rst_n),
        .refTick       (tickEdge),
        .errValid      (errEdge),
        .errWidth      (widthSync1_q),
        .lockCountSel  (lockCountSelect_q),
        .lockWindowSel (lockWindowSelect_q),
        .locked        (locked)
    );

    assign lockFlag = locked && lockIndicatorEnable_q;

    // ---------------------------------------------------------------
    // Register reads
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_q <= 8'h00;
        end else if (regRead) begin
            regRdata_q <= 8'h00;
            case (regAddr)
                ADDR_STATUS:  regRdata_q[LOCK_FLAG_BIT] <= lockFlag;
                ADDR_ST1:     regRdata_q[ST1_INV_BIT] <= statusOneInvert_q;
                ADDR_ST2:     regRdata_q[ST2_INV_BIT] <= statusTwoInvert_q;
                ADDR_LOCK_EN: regRdata_q[LOCK_EN_BIT] <= lockIndicatorEnable_q;
                ADDR_LOCKCFG: begin
                    regRdata_q[LOCK_CNT_LSB +: 2] <= lockCountSelect_q;
                    regRdata_q[LOCK_WIN_LSB +: 2] <= lockWindowSelect_q;
                end
                ADDR_OUTCFG:  regRdata_q[OUTTYPE_BIT] <= auxOutputTypeSelect_q;
                default:      regRdata_q <= 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Status pins and output buffer type
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            firstStatusOutput_q <= 1'b0;
        end else begin
            firstStatusOutput_q <= st1Sync_q[1] ^ statusOneInvert_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            secondStatusOutput_q <= 1'b0;
        end else begin
            secondStatusOutput_q <= st2Sync_q[1] ^ statusTwoInvert_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auxOutputDiff_q <= 1'b0;
        end else begin
            auxOutputDiff_q <= auxOutputTypeSelect_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auxOutputCmos_q <= 1'b1;
        end else begin
            auxOutputCmos_q <= !auxOutputTypeSelect_q;
        end
    end
endmodule

/* testbench/pll_lock_indicator_config_properties.sv */
module pll_lock_indicator_config_properties (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [4:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata_q,
    input wire logic       statusOneSrc,
    input wire logic       statusTwoSrc,
    input wire logic       firstStatusOutput_q,
    input wire logic       secondStatusOutput_q,
    input wire logic       auxOutputDiff_q,
    input wire logic       auxOutputCmos_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------
    // Shadow of writable bits
    // ----------------------------------------------------------
    logic [7:0] sh_q [0:11];
    function automatic logic [7:0] msk(input logic [4:0] a);
        case (a)
            5'h01, 5'h02: msk = 8'h80;
            5'h03: msk = 8'h08;
            5'h05: msk = 8'hf0;
            5'h0b: msk = 8'h04;
            default: msk = 8'h00;
        endcase
    endfunction
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_q <= '{3: 8'h08, 5: 8'h90, default: 8'h00};
        end else if (regWrite && msk(regAddr) != 8'h00) begin
            sh_q[regAddr] <= regWdata & msk(regAddr);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pol_one_read: assert property (regRead && regAddr == 5'h01
        |=> regRdata_q == $past(sh_q[1])) else $error("status one invert readback");
    a_pol_two_read: assert property (regRead && regAddr == 5'h02
        |=> regRdata_q == $past(sh_q[2])) else $error("status two invert readback");
    a_enable_read: assert property (regRead && regAddr == 5'h03
        |=> regRdata_q == $past(sh_q[3])) else $error("enable readback");
    a_lock_cfg_read: assert property (regRead && regAddr == 5'h05
        |=> regRdata_q == $past(sh_q[5])) else $error("lock config readback");
    a_type_read: assert property (regRead && regAddr == 5'h0b
        |=> regRdata_q == $past(sh_q[11])) else $error("output type readback");
    a_type_pins: assert property ($stable(sh_q[11]) |-> auxOutputDiff_q == sh_q[11][2]
        && auxOutputCmos_q == !auxOutputDiff_q) else $error("aux output mode wrong");
    a_status_one: assert property ($stable({statusOneSrc, sh_q[1]})[*4]
        |-> firstStatusOutput_q == (statusOneSrc ^ sh_q[1][7])) else $error("status one");
    a_status_two: assert property ($stable({statusTwoSrc, sh_q[2]})[*4]
        |-> secondStatusOutput_q == (statusTwoSrc ^ sh_q[2][7])) else $error("status two");
    a_flag_gated: assert property (regRead && regAddr == 5'h00 && !sh_q[3][3]
        |=> regRdata_q == 8'h00) else $error("lock flag set while disabled");
endmodule
bind pll_lock_indicator_config pll_lock_indicator_config_properties u_props (
    .clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata_q(regRdata_q),
    .statusOneSrc(statusOneSrc), .statusTwoSrc(statusTwoSrc),
    .firstStatusOutput_q(firstStatusOutput_q), .secondStatusOutput_q(secondStatusOutput_q),
    .auxOutputDiff_q(auxOutputDiff_q), .auxOutputCmos_q(auxOutputCmos_q));

/* testbench/tb_pll_lock_indicator_config.sv */
module tb_pll_lock_indicator_config
    import lock_cfg_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_n, regWrite, regRead, refTickPin, errValidPin;
    logic       statusOneSrc, statusTwoSrc, firstStatusOutput_q, secondStatusOutput_q;
    logic       auxOutputDiff_q, auxOutputCmos_q;
    logic [4:0] regAddr;
    logic [7:0] regWdata, regRdata_q, errWidthPin, rd, v;
    int         errors = 0, n_tests = 0, seed = 32'h030d, cyc = 0;
    pll_lock_indicator_config DUT (.clk(clk), .rst_n(rst_n), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata_q(regRdata_q),
        .refTickPin(refTickPin), .errValidPin(errValidPin), .errWidthPin(errWidthPin),
        .statusOneSrc(statusOneSrc), .statusTwoSrc(statusTwoSrc),
        .firstStatusOutput_q(firstStatusOutput_q), .secondStatusOutput_q(secondStatusOutput_q),
        .auxOutputDiff_q(auxOutputDiff_q), .auxOutputCmos_q(auxOutputCmos_q));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors = errors + 1;
            close_out();
        end
    end
    // ----------------------------------------------------------
    // Bus, pin and compare tasks
    // ----------------------------------------------------------
    task automatic cmp(input logic [7:0] e, input logic [7:0] g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("mismatch at %0t expected %h got %h", $time, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic chk(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 cmp(e, regRdata_q);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            refTickPin <= 1'b1;
            repeat (2) @(posedge clk);
            refTickPin <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (6) @(posedge clk);
    endtask
    task automatic err(input logic [7:0] w);
        errWidthPin <= w;
        repeat (3) @(posedge clk);
        errValidPin <= 1'b1;
        repeat (3) @(posedge clk);
        errValidPin <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    function automatic logic [7:0] winCyc(input logic [1:0] c);
        int t;
        t = ((c == 2'h0) ? 3 : (c == 2'h1) ? 10 : (c == 2'h2) ? 30 : 90) * 1000;
        winCyc = (t / CLK_PERIOD_PS < 1) ? 8'h01 : 8'(t / CLK_PERIOD_PS);
    endfunction
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    initial begin
        {regWrite, regRead, refTickPin, errValidPin, statusOneSrc, statusTwoSrc} = 6'h00;
        regAddr = 5'h00;
        regWdata = 8'h00;
        errWidthPin = 8'h00;
        rst_n = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        cmp(8'h01, {6'h00, auxOutputDiff_q, auxOutputCmos_q});
        chk(5'h01, 8'h00);
        chk(5'h02, 8'h00);
        chk(5'h03, 8'h08);
        chk(ADDR_LOCKCFG, 8'h90);
        chk(ADDR_OUTCFG, 8'h00);
        chk(ADDR_STATUS, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            wr(5'h01, v);
            wr(5'h02, v ^ 8'h80);
            wr(5'h10 | v[3:0], 8'hff);
            statusOneSrc <= v[1];
            statusTwoSrc <= v[2];
            repeat (5) @(posedge clk);
            cmp({6'h00, v[1] ^ v[7], v[2] ^ ~v[7]},
                {6'h00, firstStatusOutput_q, secondStatusOutput_q});
            chk(5'h01, {v[7], 7'h00});
            chk(5'h10 | v[3:0], 8'h00);
        end
        $display("test polarity done");
        wr(ADDR_OUTCFG, 8'h04);
        repeat (2) @(posedge clk);
        #1 cmp(8'h02, {6'h00, auxOutputDiff_q, auxOutputCmos_q});
        wr(ADDR_OUTCFG, 8'hfb);
        chk(ADDR_OUTCFG, 8'h00);
        $display("test output type done");
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_LOCKCFG, {2'h2, c[1:0], 4'h0});
            err(8'hff);
            chk(ADDR_STATUS, 8'h00);
            tick((32 << (2 * c)) - 1);
            chk(ADDR_STATUS, 8'h00);
            tick(1);
            chk(ADDR_STATUS, 8'h04);
        end
        $display("test lock counts done");
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_LOCKCFG, {c[1:0], 6'h00});
            err(8'hff);
            tick(32);
            v = $random(seed);
            err(v % (winCyc(c[1:0]) + 8'h01));
            err(winCyc(c[1:0]));
            chk(ADDR_STATUS, 8'h04);
            err(winCyc(c[1:0]) + 8'h01);
            chk(ADDR_STATUS, 8'h00);
        end
        $display("test lock windows done");
        tick(32);
        wr(5'h03, 8'hf7);
        chk(ADDR_STATUS, 8'h00);
        wr(5'h03, 8'h08);
        wr(ADDR_STATUS, 8'h00);
        chk(ADDR_STATUS, 8'h04);
        $display("test enable done");
        close_out();
    end
endmodule
